// ---- comparator_params.svh ----
// offsets, field positions, reset values and counts of the comparator control block
`ifndef COMPARATOR_PARAMS_SVH
`define COMPARATOR_PARAMS_SVH

`define CMP_ADDR_W 12
`define CMP_OFS_CTRL_STATUS 12'h000
`define CMP_OFS_INPUT_DISABLE 12'h004
`define CMP_OFS_MUX_CTRL 12'h008
`define CMP_OFS_IRQ_STATUS 12'h00C
`define CMP_OFS_IRQ_MASK 12'h010

`define CMP_BIT_POWER_OFF 7
`define CMP_BIT_REF_SELECT 6
`define CMP_BIT_RESULT 5
`define CMP_BIT_EVENT_FLAG 4
`define CMP_BIT_IRQ_ENABLE 3
`define CMP_BIT_RESERVED 2
`define CMP_BIT_MODE_HI 1
`define CMP_BIT_MODE_LO 0

`define CMP_BIT_POS_BUF_OFF 0
`define CMP_BIT_NEG_BUF_OFF 1
`define CMP_DIDR_MASK 8'h3F

`define CMP_BIT_CONV_ENABLE 0
`define CMP_BIT_BORROW_ENABLE 1
`define CMP_BIT_CHAN_LO 2
`define CMP_BIT_CHAN_HI 3

`define CMP_BIT_EV_COMPARE 0
`define CMP_BIT_EV_TOGGLE 1
`define CMP_EV_W 2

`define CMP_RESET_BYTE 8'h00
`define CMP_SYNC_STAGES 2
`define CMP_LEVEL_W 10

`endif

// ---- comparator_pkg.sv ----
// types shared by the comparator control block
package comparator_pkg;

    typedef enum logic [1:0] {
        MODE_TOGGLE = 2'b00,
        MODE_RESERVED = 2'b01,
        MODE_FALL = 2'b10,
        MODE_RISE = 2'b11
    } irq_mode_t;

    typedef struct packed {
        logic powerOff;
        logic refSelect;
        logic eventFlag;
        logic irqEnable;
        irq_mode_t irqMode;
    } ctrl_t;

    typedef struct packed {
        logic [1:0] channelSel;
        logic borrowEnable;
        logic converterEnable;
    } mux_ctrl_t;

    typedef struct packed {
        logic [11:0] paddr;
        logic pwrite;
        logic [31:0] pwdata;
        logic [3:0] pstrb;
    } apb_req_t;

    typedef enum logic [1:0] {
        APB_IDLE = 2'b01,
        APB_ACCESS = 2'b10
    } apb_state_t;

endpackage

// ---- comp_sync.sv ----
// flip-flop chain that brings the raw comparator decision into the core clock
module comp_sync #(
    parameter int STAGES = 2
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // raw and synchronised level
    input wire logic rawIn,
    output logic syncOut
);

    logic [STAGES-1:0] chain_r;

    // only the last stage is ever looked at; the first may be metastable
    always_ff @(posedge core_clk) begin
        if (reset) begin
            chain_r <= '0;
        end else begin
            chain_r <= {chain_r[STAGES-2:0], rawIn};
        end
    end

    assign syncOut = chain_r[STAGES-1];

endmodule

// ---- comparator_control_irq.sv ----
// comparator input selection, result synchroniser, event flag, interrupts and apb registers
`include "comparator_params.svh"

module comparator_control_irq
    import comparator_pkg::*;
#(
    parameter int LEVEL_W = `CMP_LEVEL_W,
    parameter int SYNC_STAGES = `CMP_SYNC_STAGES
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire apb_req_t apbReq,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // sampled analog levels
    input wire logic [LEVEL_W-1:0] posPinLevel,
    input wire logic [LEVEL_W-1:0] negPinLevel,
    input wire logic [LEVEL_W-1:0] refLevel,
    input wire logic [LEVEL_W-1:0] sharedPinLevel [4],
    // digital pin inputs and their port read bits
    input wire logic posPinDigital,
    input wire logic negPinDigital,
    output logic posPinRead,
    output logic negPinRead,
    output logic [5:0] inputBufferOff,
    // analog core controls
    output logic comparatorPowered,
    output logic posUsesRef,
    output logic negUsesShared,
    output logic [1:0] negSharedSel,
    output logic converterOn,
    // processor interrupt side
    input wire logic globalIrqEnable,
    input wire logic vectorTaken,
    output logic compareIrqReq,
    output logic irq
);

    ctrl_t ctrl_r;
    mux_ctrl_t mux_r;
    logic [7:0] didr_r;
    logic [`CMP_EV_W-1:0] evStatus_r;
    logic [`CMP_EV_W-1:0] evMask_r;
    apb_state_t apbState_r;
    apb_state_t apbState_nxt;
    logic [31:0] prdata_r;
    logic slvErr_r;
    logic posOut_r;
    logic negOut_r;
    logic prevResult_r;
    logic [LEVEL_W-1:0] posLevel;
    logic [LEVEL_W-1:0] negLevel;
    logic borrowActive;
    logic rawCompare;
    logic result;
    logic eventHit;
    logic toggleHit;
    logic accessDone;
    logic wrDone;
    logic rdDone;
    logic laneWr;
    logic [7:0] wrByte;
    logic addrHit;
    logic ctrlWr;
    logic didrWr;
    logic muxWr;
    logic maskWr;
    logic statusRead;
    logic [`CMP_EV_W-1:0] evReported;
    logic [7:0] ctrlByte;
    logic [7:0] muxByte;

    function automatic logic modeEvent(input irq_mode_t mode, input logic cur,
                                       input logic prev);
        logic hit;
        hit = 1'b0;
        unique case (mode)
            MODE_TOGGLE: hit = cur ^ prev;
            MODE_RESERVED: hit = 1'b0;
            MODE_FALL: hit = prev & ~cur;
            MODE_RISE: hit = cur & ~prev;
        endcase
        return hit;
    endfunction

    function automatic logic mapped(input logic [11:0] addr);
        return (addr == `CMP_OFS_CTRL_STATUS) || (addr == `CMP_OFS_INPUT_DISABLE) ||
               (addr == `CMP_OFS_MUX_CTRL) || (addr == `CMP_OFS_IRQ_STATUS) ||
               (addr == `CMP_OFS_IRQ_MASK);
    endfunction

    function automatic logic regHit(input logic strobe, input logic [11:0] addr,
                                    input logic [11:0] ofs);
        return strobe && (addr == ofs);
    endfunction

    // a disabled input buffer reads as zero whatever the pin does
    function automatic logic pinGate(input logic pin, input logic bufOff);
        return pin & ~bufOff;
    endfunction

    // input selection
    assign borrowActive = mux_r.borrowEnable & ~mux_r.converterEnable;
    assign posLevel = ctrl_r.refSelect ? refLevel : posPinLevel;
    assign negLevel = borrowActive ? sharedPinLevel[mux_r.channelSel] : negPinLevel;

    // an unpowered comparator is taken to output low; this can itself raise an event
    always_comb begin
        if (ctrl_r.powerOff) begin
            rawCompare = 1'b0;
        end else begin
            rawCompare = (posLevel > negLevel);
        end
    end

    comp_sync #(
        .STAGES(SYNC_STAGES)
    ) u_sync (
        .core_clk(core_clk),
        .reset(reset),
        .rawIn(rawCompare),
        .syncOut(result)
    );

    always_ff @(posedge core_clk) begin
        if (reset) begin
            prevResult_r <= 1'b0;
        end else begin
            prevResult_r <= result;
        end
    end

    assign eventHit = modeEvent(ctrl_r.irqMode, result, prevResult_r);
    assign toggleHit = result ^ prevResult_r;

    // apb handshake: no wait state; read data comes from a flop loaded in the setup cycle
    always_comb begin
        apbState_nxt = apbState_r;
        unique case (apbState_r)
            APB_IDLE: begin
                if (psel && !penable) begin
                    apbState_nxt = APB_ACCESS;
                end
            end
            APB_ACCESS: begin
                apbState_nxt = APB_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            apbState_r <= APB_IDLE;
        end else begin
            apbState_r <= apbState_nxt;
        end
    end

    assign accessDone = (apbState_r == APB_ACCESS) && psel && penable;
    assign addrHit = mapped(apbReq.paddr);
    assign wrDone = accessDone && apbReq.pwrite && addrHit;
    assign rdDone = accessDone && !apbReq.pwrite && addrHit;
    assign laneWr = wrDone && apbReq.pstrb[0];
    assign wrByte = apbReq.pwdata[7:0];

    // register selects shared by the write processes and the read-clear
    assign ctrlWr = regHit(laneWr, apbReq.paddr, `CMP_OFS_CTRL_STATUS);
    assign didrWr = regHit(laneWr, apbReq.paddr, `CMP_OFS_INPUT_DISABLE);
    assign muxWr = regHit(laneWr, apbReq.paddr, `CMP_OFS_MUX_CTRL);
    assign maskWr = regHit(laneWr, apbReq.paddr, `CMP_OFS_IRQ_MASK);
    assign statusRead = regHit(rdDone, apbReq.paddr, `CMP_OFS_IRQ_STATUS);
    // only bits already handed out are cleared, so an event after setup survives
    assign evReported = prdata_r[`CMP_EV_W-1:0];

    // read view of the control byte; the reserved bit stays low
    always_comb begin
        ctrlByte = 8'h00;
        ctrlByte[`CMP_BIT_POWER_OFF] = ctrl_r.powerOff;
        ctrlByte[`CMP_BIT_REF_SELECT] = ctrl_r.refSelect;
        ctrlByte[`CMP_BIT_RESULT] = result;
        ctrlByte[`CMP_BIT_EVENT_FLAG] = ctrl_r.eventFlag;
        ctrlByte[`CMP_BIT_IRQ_ENABLE] = ctrl_r.irqEnable;
        ctrlByte[`CMP_BIT_RESERVED] = 1'b0;
        ctrlByte[`CMP_BIT_MODE_HI:`CMP_BIT_MODE_LO] = ctrl_r.irqMode;
    end

    always_comb begin
        muxByte = 8'h00;
        muxByte[`CMP_BIT_CONV_ENABLE] = mux_r.converterEnable;
        muxByte[`CMP_BIT_BORROW_ENABLE] = mux_r.borrowEnable;
        muxByte[`CMP_BIT_CHAN_HI:`CMP_BIT_CHAN_LO] = mux_r.channelSel;
    end

    // read data and error captured in the setup cycle
    always_ff @(posedge core_clk) begin
        if (reset) begin
            prdata_r <= 32'h0000_0000;
            slvErr_r <= 1'b0;
        end else if (apbState_r == APB_IDLE && psel && !penable) begin
            slvErr_r <= !addrHit;
            prdata_r <= 32'h0000_0000;
            if (!apbReq.pwrite) begin
                unique case (apbReq.paddr)
                    `CMP_OFS_CTRL_STATUS: begin
                        prdata_r[7:0] <= ctrlByte;
                    end
                    `CMP_OFS_INPUT_DISABLE: begin
                        prdata_r[7:0] <= didr_r;
                    end
                    `CMP_OFS_MUX_CTRL: begin
                        prdata_r[7:0] <= muxByte;
                    end
                    `CMP_OFS_IRQ_STATUS: begin
                        prdata_r[`CMP_EV_W-1:0] <= evStatus_r;
                    end
                    `CMP_OFS_IRQ_MASK: begin
                        prdata_r[`CMP_EV_W-1:0] <= evMask_r;
                    end
                    default: begin
                        prdata_r <= 32'h0000_0000;
                    end
                endcase
            end
        end
    end

    assign pready = (apbState_r == APB_ACCESS);
    assign prdata = prdata_r;
    assign pslverr = pready & slvErr_r;

    // control bits; the event flag has its own process below
    always_ff @(posedge core_clk) begin
        if (reset) begin
            ctrl_r.powerOff <= 1'b0;
            ctrl_r.refSelect <= 1'b0;
            ctrl_r.irqEnable <= 1'b0;
            ctrl_r.irqMode <= MODE_TOGGLE;
        end else if (ctrlWr) begin
            ctrl_r.powerOff <= wrByte[`CMP_BIT_POWER_OFF];
            ctrl_r.refSelect <= wrByte[`CMP_BIT_REF_SELECT];
            ctrl_r.irqEnable <= wrByte[`CMP_BIT_IRQ_ENABLE];
            ctrl_r.irqMode <= irq_mode_t'(wrByte[`CMP_BIT_MODE_HI:`CMP_BIT_MODE_LO]);
        end
    end

    // a power change may itself raise the flag, a mode change alone cannot; software masks first
    always_ff @(posedge core_clk) begin
        if (reset) begin
            ctrl_r.eventFlag <= 1'b0;
        end else if (eventHit) begin
            ctrl_r.eventFlag <= 1'b1;
        end else if (vectorTaken) begin
            ctrl_r.eventFlag <= 1'b0;
        end else if (ctrlWr && wrByte[`CMP_BIT_EVENT_FLAG]) begin
            ctrl_r.eventFlag <= 1'b0;
        end
    end

    assign compareIrqReq = ctrl_r.eventFlag & ctrl_r.irqEnable & globalIrqEnable;

    // digital input disable
    always_ff @(posedge core_clk) begin
        if (reset) begin
            didr_r <= `CMP_RESET_BYTE;
        end else if (didrWr) begin
            didr_r <= wrByte & `CMP_DIDR_MASK;
        end
    end

    // port read bits registered so they stay clean data outputs
    always_ff @(posedge core_clk) begin
        if (reset) begin
            posOut_r <= 1'b0;
            negOut_r <= 1'b0;
        end else begin
            posOut_r <= pinGate(posPinDigital, didr_r[`CMP_BIT_POS_BUF_OFF]);
            negOut_r <= pinGate(negPinDigital, didr_r[`CMP_BIT_NEG_BUF_OFF]);
        end
    end

    assign posPinRead = posOut_r;
    assign negPinRead = negOut_r;
    assign inputBufferOff = didr_r[5:0];

    // converter enable and multiplexer borrow
    always_ff @(posedge core_clk) begin
        if (reset) begin
            mux_r <= '0;
        end else if (muxWr) begin
            mux_r.converterEnable <= wrByte[`CMP_BIT_CONV_ENABLE];
            mux_r.borrowEnable <= wrByte[`CMP_BIT_BORROW_ENABLE];
            mux_r.channelSel <= wrByte[`CMP_BIT_CHAN_HI:`CMP_BIT_CHAN_LO];
        end
    end

    assign converterOn = mux_r.converterEnable;
    assign comparatorPowered = ~ctrl_r.powerOff;
    assign posUsesRef = ctrl_r.refSelect;
    assign negUsesShared = borrowActive;
    assign negSharedSel = mux_r.channelSel;

    // sticky event status, cleared by reading it; a new event wins
    always_ff @(posedge core_clk) begin
        if (reset) begin
            evStatus_r <= '0;
        end else begin
            for (int i = 0; i < `CMP_EV_W; i++) begin
                if ((i == `CMP_BIT_EV_COMPARE) ? eventHit : toggleHit) begin
                    evStatus_r[i] <= 1'b1;
                end else if (statusRead && evReported[i]) begin
                    evStatus_r[i] <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            evMask_r <= '0;
        end else if (maskWr) begin
            evMask_r <= wrByte[`CMP_EV_W-1:0];
        end
    end

    assign irq = |(evStatus_r & evMask_r);

endmodule

// ---- analog_front.sv ----
// model of the analog pins and reference seen by the comparator
module analog_front (
    // bench controls
    input wire logic posHigh,
    input wire logic [1:0] hotPin,
    // sampled levels
    output logic [9:0] posLevel,
    output logic [9:0] negLevel,
    output logic [9:0] refLevel,
    output logic [9:0] sharedLevel [4]
);
    timeunit 1ns;
    timeprecision 1ns;
    // dedicated negative pin sits between both positive levels
    assign posLevel = posHigh ? 10'h258 : 10'h190;
    assign negLevel = 10'h1C2;
    assign refLevel = 10'h2BC;
    // one shared pin above every positive level, the rest far below
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            sharedLevel[i] = (i == hotPin) ? 10'h2BC : 10'h064;
        end
    end
endmodule

// ---- comparator_control_irq_assertions.sv ----
// port checks of the comparator control block
`include "comparator_params.svh"
module comparator_control_irq_assertions
    import comparator_pkg::*;
(
    // clock, reset, apb
    input wire logic core_clk,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire apb_req_t apbReq,
    input wire logic [31:0] prdata,
    input wire logic pready,
    // pins and analog controls
    input wire logic posPinRead,
    input wire logic negPinRead,
    input wire logic [5:0] inputBufferOff,
    input wire logic comparatorPowered,
    input wire logic posUsesRef,
    input wire logic negUsesShared,
    input wire logic [1:0] negSharedSel,
    input wire logic converterOn,
    // interrupt
    input wire logic globalIrqEnable,
    input wire logic vectorTaken,
    input wire logic compareIrqReq
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (reset);
    logic wrOk;
    assign wrOk = psel && penable && pready && apbReq.pwrite && apbReq.pstrb[0];
    sequence ctl_wr_s;
        wrOk && apbReq.paddr == `CMP_OFS_CTRL_STATUS;
    endsequence
    sequence mux_wr_s;
        wrOk && apbReq.paddr == `CMP_OFS_MUX_CTRL;
    endsequence
    // five cycles off lets the synchroniser and edge detector go quiet
    sequence off_s;
        !comparatorPowered [*5];
    endsequence
    ctrl_write_a: assert property (ctl_wr_s |=>
        comparatorPowered == !$past(apbReq.pwdata[7]) && posUsesRef == $past(apbReq.pwdata[6]))
        else $error("power or reference bit wrong");
    mux_write_a: assert property (mux_wr_s |=>
        negSharedSel == $past(apbReq.pwdata[3:2]) && converterOn == $past(apbReq.pwdata[0]))
        else $error("mux control wrong");
    rsvd_zero_a: assert property (psel && penable && pready && !apbReq.pwrite
        && apbReq.paddr == `CMP_OFS_CTRL_STATUS |-> prdata[2] == 1'b0 && prdata[31:8] == '0)
        else $error("reserved bits read nonzero");
    irq_gate_a: assert property (compareIrqReq |-> globalIrqEnable)
        else $error("request without global enable");
    vector_clear_a: assert property (off_s ##0 vectorTaken |=> !compareIrqReq)
        else $error("vector did not clear flag");
    mux_excl_a: assert property (converterOn |-> !negUsesShared)
        else $error("shared pin used while converter on");
    pos_buf_a: assert property (inputBufferOff[0] |=> !posPinRead)
        else $error("positive pin read while buffer off");
    neg_buf_a: assert property (inputBufferOff[1] |=> !negPinRead)
        else $error("negative pin read while buffer off");
endmodule
bind comparator_control_irq comparator_control_irq_assertions checks (.core_clk, .reset, .psel,
    .penable, .apbReq, .prdata, .pready, .posPinRead, .negPinRead, .inputBufferOff,
    .comparatorPowered, .posUsesRef, .negUsesShared, .negSharedSel, .converterOn,
    .globalIrqEnable, .vectorTaken, .compareIrqReq);

// ---- comparator_control_irq_test.sv ----
// self-checking bench of the comparator control block
`include "comparator_params.svh"
module comparator_control_irq_test;
    import comparator_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [11:0] CTL = `CMP_OFS_CTRL_STATUS;
    localparam logic [11:0] DIS = `CMP_OFS_INPUT_DISABLE;
    localparam logic [11:0] MUX = `CMP_OFS_MUX_CTRL;
    localparam logic [11:0] IST = `CMP_OFS_IRQ_STATUS;
    localparam logic [11:0] IMK = `CMP_OFS_IRQ_MASK;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    apb_req_t apbReq = '0;
    logic posHigh = 1'b0;
    logic [1:0] hotPin = 2'b00;
    logic pinHigh = 1'b1;
    logic globalIrqEnable = 1'b1;
    logic vectorTaken = 1'b0;
    logic [9:0] posPinLevel, negPinLevel, refLevel;
    logic [9:0] sharedPinLevel [4];
    logic [31:0] prdata, rd;
    logic [5:0] inputBufferOff;
    logic [1:0] negSharedSel;
    logic pready, pslverr, err, posPinRead, negPinRead, comparatorPowered;
    logic posUsesRef, negUsesShared, converterOn, compareIrqReq, irq;
    int num_errors = 0;
    int n_compared = 0;
    int cycles = 0;
    comparator_control_irq DUT (.core_clk, .reset, .psel, .penable, .apbReq, .prdata, .pready,
        .pslverr, .posPinLevel, .negPinLevel, .refLevel, .sharedPinLevel,
        .posPinDigital(pinHigh), .negPinDigital(pinHigh), .posPinRead, .negPinRead,
        .inputBufferOff, .comparatorPowered, .posUsesRef, .negUsesShared, .negSharedSel,
        .converterOn, .globalIrqEnable, .vectorTaken, .compareIrqReq, .irq);
    analog_front model (.posHigh, .hotPin, .posLevel(posPinLevel), .negLevel(negPinLevel),
        .refLevel, .sharedLevel(sharedPinLevel));
    always #20 core_clk = ~core_clk;
    // the run needs well under a thousand cycles
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 3000) begin
            num_errors++;
            print_verdict();
        end
    end
    task automatic print_verdict();
        if (num_errors == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic chk(logic [31:0] seen, logic [31:0] expected, string what);
        n_compared++;
        if (seen !== expected) begin
            num_errors++;
            $display("unexpected %s expected %h seen %h", what, expected, seen);
        end
    endtask
    task automatic tick(int n);
        repeat (n) @(posedge core_clk);
    endtask
    // the edge ahead of setup keeps back-to-back calls from double driving psel
    task automatic apb(logic [11:0] addr, logic wr, logic [31:0] data);
        @(posedge core_clk);
        psel <= 1'b1;
        apbReq <= '{addr, wr, data, 4'h1};
        @(posedge core_clk);
        penable <= 1'b1;
        // pready and read data are taken at the rising edge that ends the access
        do @(posedge core_clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic drive(logic v);
        @(posedge core_clk);
        posHigh <= v;
        tick(3);
        apb(CTL, 1'b0, '0);
    endtask
    task automatic t_reset();
        apb(CTL, 1'b0, '0);
        chk(rd & 32'hFFFF_FFDF, '0, "ctrl reset");
        apb(DIS, 1'b0, '0);
        chk(rd, '0, "disable reset");
        chk(comparatorPowered, 1'b1, "powered");
    endtask
    task automatic t_regs();
        apb(CTL, 1'b1, 32'h0000_00F7);
        apb(CTL, 1'b0, '0);
        chk(rd, 32'h0000_00C3, "ctrl readback");
        chk({comparatorPowered, posUsesRef}, 2'b01, "power and ref");
        apb(CTL, 1'b1, 32'h0000_0010);
        apb(DIS, 1'b1, 32'h0000_00FF);
        apb(DIS, 1'b0, '0);
        chk(rd, 32'h0000_003F, "disable readback");
        chk({inputBufferOff, posPinRead, negPinRead}, 8'hFC, "buffers off");
        apb(DIS, 1'b1, '0);
        tick(1);
        @(negedge core_clk);
        chk({posPinRead, negPinRead}, 2'b11, "pins read");
        @(posedge core_clk);
        pinHigh <= 1'b0;
        tick(1);
        @(negedge core_clk);
        chk({posPinRead, negPinRead}, 2'b00, "pins low");
        @(posedge core_clk);
        pinHigh <= 1'b1;
        apb(12'h020, 1'b0, '0);
        chk(err, 1'b1, "unmapped error");
        chk(rd, '0, "unmapped data");
    endtask
    // enable is off whenever the mode changes
    task automatic t_modes();
        for (int i = 0; i < 4; i++) begin
            apb(CTL, 1'b1, 32'h0000_0010 | i);
            apb(CTL, 1'b1, 32'h0000_0018 | i);
            drive(1'b1);
            chk(rd[5:4], {1'b1, i == 0 || i == 3}, "rise flag");
            chk(compareIrqReq, i == 0 || i == 3, "rise request");
            apb(CTL, 1'b1, 32'h0000_0018 | i);
            drive(1'b0);
            chk(rd[5:4], {1'b0, i == 0 || i == 2}, "fall flag");
            apb(CTL, 1'b1, 32'h0000_0010 | i);
        end
    endtask
    task automatic t_irq();
        apb(IST, 1'b0, '0);
        apb(IMK, 1'b1, '0);
        apb(CTL, 1'b1, 32'h0000_0018);
        drive(1'b1);
        chk(irq, 1'b0, "irq masked");
        apb(IMK, 1'b1, 32'h0000_0003);
        @(negedge core_clk);
        chk(irq, 1'b1, "irq unmasked");
        apb(IST, 1'b0, '0);
        chk(rd, 32'h0000_0003, "irq status");
        @(negedge core_clk);
        chk(irq, 1'b0, "status cleared");
        chk(compareIrqReq, 1'b1, "request pending");
        @(posedge core_clk);
        globalIrqEnable <= 1'b0;
        @(negedge core_clk);
        chk(compareIrqReq, 1'b0, "global gate");
        @(posedge core_clk);
        globalIrqEnable <= 1'b1;
        apb(CTL, 1'b1, 32'h0000_0010);
        apb(CTL, 1'b1, 32'h0000_0080);
        tick(6);
        apb(CTL, 1'b1, 32'h0000_0088);
        @(negedge core_clk);
        chk(compareIrqReq, 1'b1, "power off event");
        @(posedge core_clk);
        vectorTaken <= 1'b1;
        @(posedge core_clk);
        vectorTaken <= 1'b0;
        @(negedge core_clk);
        chk(compareIrqReq, 1'b0, "vector clear");
        apb(CTL, 1'b1, 32'h0000_0080);
        apb(CTL, 1'b1, 32'h0000_0010);
    endtask
    task automatic t_mux();
        for (int s = 0; s < 4; s++) begin
            @(posedge core_clk);
            hotPin <= 2'(s);
            apb(MUX, 1'b1, 32'h0000_0002 | (s << 2));
            tick(2);
            apb(CTL, 1'b0, '0);
            chk({rd[5], negUsesShared, negSharedSel}, {2'b01, 2'(s)}, "borrowed");
            apb(MUX, 1'b1, 32'h0000_0003 | (s << 2));
            tick(2);
            apb(CTL, 1'b0, '0);
            chk({rd[5], negUsesShared, converterOn}, 3'b101, "dedicated");
        end
        @(posedge core_clk);
        posHigh <= 1'b0;
        apb(CTL, 1'b1, 32'h0000_0040);
        tick(2);
        apb(CTL, 1'b0, '0);
        chk(rd[6:5], 2'b11, "reference input");
    endtask
    initial begin
        tick(4);
        reset <= 1'b0;
        t_reset();
        t_regs();
        t_modes();
        t_irq();
        t_mux();
        print_verdict();
    end
endmodule
